// ---- csw_capture_watchdog.sv ----
// capture source selection, capture strobes and digital watchdog register block
// Contract
// - capture0 selector in config bits 2:0
// - capture1 selector in config bits 6:4
// - six codes pick port tx/rx events
// - reserved config bits; software writes zeros
// - enable control register enables watchdog
// - preload register sets watchdog timeout
// - state register shows watchdog status
// - correct key pair restarts the timeout
// - watchdog disabled after reset
// - missed key pair before zero resets processor
// - counters and captures on system clock two
`timescale 1ns/100ps
module csw_capture_watchdog #(
    parameter int CNT_W = 32,
    parameter logic [31:0] PRELOAD_RESET = 32'hffffffff
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire csw_pkg::csw_req_t REG_REQ,
    output logic [31:0] REG_RDATA,
    input wire logic [csw_pkg::NUM_SOURCES-1:0] DMA_EVENT,
    input wire logic [CNT_W-1:0] COUNT0,
    input wire logic [CNT_W-1:0] COUNT1,
    output logic CAPTURE0_STROBE,
    output logic CAPTURE1_STROBE,
    output logic [CNT_W-1:0] CAPTURED0,
    output logic [CNT_W-1:0] CAPTURED1,
    output logic WD_RESET_REQ,
    output logic IRQ
);

    generate
        if (CNT_W < 16 || CNT_W > 32)
        begin : g_bad_width
            $error("CNT_W must lie between 16 and 32");
        end
        // a reset count wider than the counter would be cut silently
        if ((PRELOAD_RESET >> CNT_W) != 32'h0)
        begin : g_bad_preload
            $error("PRELOAD_RESET must fit in CNT_W bits");
        end
    endgenerate

    // event synchroniser, edge memory
    logic [csw_pkg::NUM_SOURCES-1:0] ev_meta;
    logic [csw_pkg::NUM_SOURCES-1:0] ev_sync;
    logic [csw_pkg::NUM_SOURCES-1:0] ev_prev;

    // register state
    logic [csw_pkg::SEL_W-1:0] cap0_sel;
    logic [csw_pkg::SEL_W-1:0] cap1_sel;
    logic wd_enabled;
    logic [CNT_W-1:0] wd_preload;
    logic [CNT_W-1:0] wd_count;
    logic wd_expired;
    csw_pkg::csw_key_state_t key_state;
    logic [csw_pkg::EV_W-1:0] ev_status;
    logic [csw_pkg::EV_W-1:0] ev_mask;
    logic [31:0] rdata;
    logic cap0_strobe;
    logic cap1_strobe;
    logic [CNT_W-1:0] captured0;
    logic [CNT_W-1:0] captured1;

    logic [csw_pkg::NUM_SOURCES-1:0] next_ev_meta;
    logic [csw_pkg::NUM_SOURCES-1:0] next_ev_sync;
    logic [csw_pkg::NUM_SOURCES-1:0] next_ev_prev;
    logic [csw_pkg::SEL_W-1:0] next_cap0_sel;
    logic [csw_pkg::SEL_W-1:0] next_cap1_sel;
    logic next_wd_enabled;
    logic [CNT_W-1:0] next_wd_preload;
    logic [CNT_W-1:0] next_wd_count;
    logic next_wd_expired;
    csw_pkg::csw_key_state_t next_key_state;
    logic [csw_pkg::EV_W-1:0] next_ev_status;
    logic [csw_pkg::EV_W-1:0] next_ev_mask;
    logic [31:0] next_rdata;
    logic next_cap0_strobe;
    logic next_cap1_strobe;
    logic [CNT_W-1:0] next_captured0;
    logic [CNT_W-1:0] next_captured1;

    // combinational helpers
    logic [csw_pkg::NUM_SOURCES-1:0] ev_rise;
    logic sel0_hit;
    logic sel1_hit;
    logic wr_config;
    logic wr_enable;
    logic wr_preload;
    logic wr_key;
    logic wr_mask;
    logic rd_status;
    logic key_reload;
    logic key_bad;
    logic [csw_pkg::EV_W-1:0] ev_set;
    logic [31:0] state_word;

    // reserved codes pick nothing, so a bad selector never fires a capture
    function automatic logic pick_event(
        input logic [csw_pkg::SEL_W-1:0] sel,
        input logic [csw_pkg::NUM_SOURCES-1:0] rise
    );
        logic hit;
        hit = 1'b0;
        unique case (sel)
            csw_pkg::SEL_PORT0_TX: hit = rise[0];
            csw_pkg::SEL_PORT0_RX: hit = rise[1];
            csw_pkg::SEL_PORT1_TX: hit = rise[2];
            csw_pkg::SEL_PORT1_RX: hit = rise[3];
            csw_pkg::SEL_PORT2_TX: hit = rise[4];
            csw_pkg::SEL_PORT2_RX: hit = rise[5];
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    always_comb
    begin
        // two-flop synchroniser, edge seen only past the second flop
        next_ev_meta = DMA_EVENT;
        next_ev_sync = ev_meta;
        next_ev_prev = ev_sync;
        ev_rise = ev_sync & ~ev_prev;
        sel0_hit = pick_event(cap0_sel, ev_rise);
        sel1_hit = pick_event(cap1_sel, ev_rise);

        // capture strobes and latches, all on the one system clock
        next_cap0_strobe = sel0_hit;
        next_cap1_strobe = sel1_hit;
        next_captured0 = sel0_hit ? COUNT0 : captured0;
        next_captured1 = sel1_hit ? COUNT1 : captured1;
    end

    // register, watchdog and event group
    always_comb
    begin

        // write decode
        wr_config = REG_REQ.wr && (REG_REQ.addr == csw_pkg::ADDR_CAPTURE_SOURCE_CONFIG);
        wr_enable = REG_REQ.wr && (REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_ENABLE_CONTROL);
        wr_preload = REG_REQ.wr && (REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_PRELOAD_VALUE);
        wr_key = REG_REQ.wr && (REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_SERVICE_KEY);
        wr_mask = REG_REQ.wr && (REG_REQ.addr == csw_pkg::ADDR_EVENT_MASK);
        rd_status = REG_REQ.rd && (REG_REQ.addr == csw_pkg::ADDR_EVENT_STATUS);

        // capture source selectors; reserved write bits are dropped
        next_cap0_sel = cap0_sel;
        next_cap1_sel = cap1_sel;
        if (wr_config)
        begin
            next_cap0_sel = REG_REQ.wdata[csw_pkg::CAP0_SEL_LSB +: csw_pkg::SEL_W];
            next_cap1_sel = REG_REQ.wdata[csw_pkg::CAP1_SEL_LSB +: csw_pkg::SEL_W];
        end

        next_wd_preload = wr_preload ? REG_REQ.wdata[CNT_W-1:0] : wd_preload;
        next_ev_mask = wr_mask ? REG_REQ.wdata[csw_pkg::EV_W-1:0] : ev_mask;

        // key sequence: any other value written restarts the pair
        next_key_state = key_state;
        key_reload = 1'b0;
        key_bad = 1'b0;
        if (wr_key)
        begin
            unique case (key_state)
                csw_pkg::KEY_WAIT_FIRST:
                begin
                    if (REG_REQ.wdata[csw_pkg::KEY_W-1:0] == csw_pkg::KEY_FIRST)
                    begin
                        next_key_state = csw_pkg::KEY_WAIT_SECOND;
                    end
                    else
                    begin
                        key_bad = 1'b1;
                    end
                end
                csw_pkg::KEY_WAIT_SECOND:
                begin
                    next_key_state = csw_pkg::KEY_WAIT_FIRST;
                    if (REG_REQ.wdata[csw_pkg::KEY_W-1:0] == csw_pkg::KEY_SECOND)
                    begin
                        key_reload = 1'b1;
                    end
                    else if (REG_REQ.wdata[csw_pkg::KEY_W-1:0] == csw_pkg::KEY_FIRST)
                    begin
                        next_key_state = csw_pkg::KEY_WAIT_SECOND;
                    end
                    else
                    begin
                        key_bad = 1'b1;
                    end
                end
                default:
                begin
                    next_key_state = csw_pkg::KEY_WAIT_FIRST;
                end
            endcase
        end

        // watchdog: once enabled it stays enabled until reset
        next_wd_enabled = wd_enabled | wr_enable;
        next_wd_count = wd_count;
        next_wd_expired = wd_expired;
        if (wr_enable && !wd_enabled)
        begin
            next_wd_count = next_wd_preload;
        end
        else if (wd_enabled && !wd_expired)
        begin
            if (key_reload)
            begin
                next_wd_count = next_wd_preload;
            end
            else if (wd_count == '0)
            begin
                next_wd_expired = 1'b1;
            end
            else
            begin
                next_wd_count = wd_count - 1'b1;
            end
        end

        // sticky events; a set in the clearing read's cycle survives
        ev_set = '0;
        ev_set[csw_pkg::EV_CAPTURE0] = sel0_hit;
        ev_set[csw_pkg::EV_CAPTURE1] = sel1_hit;
        ev_set[csw_pkg::EV_WD_EXPIRED] = next_wd_expired & ~wd_expired;
        ev_set[csw_pkg::EV_BAD_KEY] = key_bad;
        next_ev_status = (rd_status ? '0 : ev_status) | ev_set;

        state_word = '0;
        state_word[csw_pkg::ST_ANALOG_EXPIRED] = 1'b0;
        state_word[csw_pkg::ST_DIGITAL_EXPIRED] = wd_expired;
        state_word[csw_pkg::ST_DIGITAL_ENABLED] = wd_enabled;
        state_word[csw_pkg::ST_KEY_ARMED] = (key_state == csw_pkg::KEY_WAIT_SECOND);

        // read data stands one cycle only; unmapped and write-only read zero
        next_rdata = '0;
        if (REG_REQ.rd)
        begin
            unique case (REG_REQ.addr)
                csw_pkg::ADDR_CAPTURE_SOURCE_CONFIG:
                begin
                    // reserved bits read as zero
                    next_rdata[csw_pkg::CAP0_SEL_LSB +: csw_pkg::SEL_W] = cap0_sel;
                    next_rdata[csw_pkg::CAP1_SEL_LSB +: csw_pkg::SEL_W] = cap1_sel;
                end
                csw_pkg::ADDR_WATCHDOG_ENABLE_CONTROL:
                begin
                    next_rdata[0] = wd_enabled;
                end
                csw_pkg::ADDR_WATCHDOG_PRELOAD_VALUE:
                begin
                    next_rdata[CNT_W-1:0] = wd_preload;
                end
                csw_pkg::ADDR_WATCHDOG_STATE:
                begin
                    next_rdata = state_word;
                end
                csw_pkg::ADDR_WATCHDOG_DOWN_COUNT:
                begin
                    next_rdata[CNT_W-1:0] = wd_count;
                end
                csw_pkg::ADDR_EVENT_STATUS:
                begin
                    next_rdata[csw_pkg::EV_W-1:0] = ev_status;
                end
                csw_pkg::ADDR_EVENT_MASK:
                begin
                    next_rdata[csw_pkg::EV_W-1:0] = ev_mask;
                end
                default:
                begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // capture group registers
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            ev_meta <= '0;
            ev_sync <= '0;
            ev_prev <= '0;
            cap0_strobe <= 1'b0;
            cap1_strobe <= 1'b0;
            captured0 <= '0;
            captured1 <= '0;
        end
        else
        begin
            ev_meta <= next_ev_meta;
            ev_sync <= next_ev_sync;
            ev_prev <= next_ev_prev;
            cap0_strobe <= next_cap0_strobe;
            cap1_strobe <= next_cap1_strobe;
            captured0 <= next_captured0;
            captured1 <= next_captured1;
        end
    end

    // register, watchdog and event group registers
    always_ff @(posedge SYS_CLK)
    begin
        if (!RSTN)
        begin
            cap0_sel <= csw_pkg::SEL_RESET;
            cap1_sel <= csw_pkg::SEL_RESET;
            wd_enabled <= 1'b0;
            wd_preload <= PRELOAD_RESET[CNT_W-1:0];
            wd_count <= PRELOAD_RESET[CNT_W-1:0];
            wd_expired <= 1'b0;
            key_state <= csw_pkg::KEY_WAIT_FIRST;
            ev_status <= csw_pkg::EV_RESET;
            ev_mask <= csw_pkg::EV_RESET;
            rdata <= '0;
        end
        else
        begin
            cap0_sel <= next_cap0_sel;
            cap1_sel <= next_cap1_sel;
            wd_enabled <= next_wd_enabled;
            wd_preload <= next_wd_preload;
            wd_count <= next_wd_count;
            wd_expired <= next_wd_expired;
            key_state <= next_key_state;
            ev_status <= next_ev_status;
            ev_mask <= next_ev_mask;
            rdata <= next_rdata;
        end
    end

    assign REG_RDATA = rdata;
    assign CAPTURE0_STROBE = cap0_strobe;
    assign CAPTURE1_STROBE = cap1_strobe;
    assign CAPTURED0 = captured0;
    assign CAPTURED1 = captured1;
    // held until the processor reset removes it
    assign WD_RESET_REQ = wd_expired;
    assign IRQ = |(ev_status & ev_mask);

endmodule

// ---- csw_dma_model.sv ----
// model: six serial port DMA event lines, each pulsed on request
`timescale 1ns/100ps
module csw_dma_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [5:0] fire,
    output logic [5:0] dma_event
);
    logic [5:0][2:0] hold;
    logic [5:0][2:0] next_hold;
    // requests while hold is nonzero (pulse and first two gap cycles) are dropped so events never merge
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (fire[i] && hold[i] == 3'h0)
                next_hold[i] = 3'h5;
            else if (hold[i] != 3'h0)
                next_hold[i] = hold[i] - 3'h1;
            else
                next_hold[i] = 3'h0;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            hold <= '0;
        else
            hold <= next_hold;
    end
    // three cycles high, at least three low
    always_comb
    begin
        for (int i = 0; i < 6; i++)
            dma_event[i] = hold[i] > 3'h2;
    end
endmodule

// ---- csw_pkg.sv ----
// package: register map, field layout, keys and types of the capture/watchdog block
package csw_pkg;

    // byte addresses of the register file
    localparam logic [31:0] ADDR_CAPTURE_SOURCE_CONFIG = 32'h40000014;
    localparam logic [31:0] ADDR_WATCHDOG_ENABLE_CONTROL = 32'h42000090;
    localparam logic [31:0] ADDR_WATCHDOG_PRELOAD_VALUE = 32'h42000094;
    localparam logic [31:0] ADDR_WATCHDOG_STATE = 32'h42000098;
    localparam logic [31:0] ADDR_WATCHDOG_SERVICE_KEY = 32'h4200009c;
    localparam logic [31:0] ADDR_WATCHDOG_DOWN_COUNT = 32'h420000a0;
    localparam logic [31:0] ADDR_EVENT_STATUS = 32'h420000a4;
    localparam logic [31:0] ADDR_EVENT_MASK = 32'h420000a8;

    // capture source field layout
    localparam int SEL_W = 3;
    localparam int CAP0_SEL_LSB = 0;
    localparam int CAP1_SEL_LSB = 4;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam int NUM_SOURCES = 6;
    localparam logic [SEL_W-1:0] SEL_PORT0_TX = 3'h0;
    localparam logic [SEL_W-1:0] SEL_PORT0_RX = 3'h1;
    localparam logic [SEL_W-1:0] SEL_PORT1_TX = 3'h2;
    localparam logic [SEL_W-1:0] SEL_PORT1_RX = 3'h3;
    localparam logic [SEL_W-1:0] SEL_PORT2_TX = 3'h4;
    localparam logic [SEL_W-1:0] SEL_PORT2_RX = 3'h5;

    // service keys, low 16 bits of the write data
    localparam int KEY_W = 16;
    localparam logic [KEY_W-1:0] KEY_FIRST = 16'he51a;
    localparam logic [KEY_W-1:0] KEY_SECOND = 16'ha35c;

    // watchdog_state bit positions
    localparam int ST_ANALOG_EXPIRED = 0;
    localparam int ST_DIGITAL_EXPIRED = 1;
    localparam int ST_DIGITAL_ENABLED = 2;
    localparam int ST_KEY_ARMED = 3;

    // event status / mask bit positions
    localparam int EV_W = 4;
    localparam int EV_CAPTURE0 = 0;
    localparam int EV_CAPTURE1 = 1;
    localparam int EV_WD_EXPIRED = 2;
    localparam int EV_BAD_KEY = 3;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;

    // key sequence states
    typedef enum logic [1:0] {
        KEY_WAIT_FIRST = 2'b01,
        KEY_WAIT_SECOND = 2'b10
    } csw_key_state_t;

    // one register bus request
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } csw_req_t;

endpackage

// ---- csw_props.sv ----
// checker: port-level properties of the capture/watchdog block
`timescale 1ns/100ps
module csw_props #(
    parameter int CNT_W = 32
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire csw_pkg::csw_req_t REG_REQ,
    input wire logic [31:0] REG_RDATA,
    input wire logic [CNT_W-1:0] COUNT0,
    input wire logic CAPTURE0_STROBE,
    input wire logic [CNT_W-1:0] CAPTURED0,
    input wire logic WD_RESET_REQ,
    input wire logic IRQ
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);
    property p_strobe_pulse;
        CAPTURE0_STROBE |=> !CAPTURE0_STROBE;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
    property p_capture_value;
        CAPTURE0_STROBE |-> CAPTURED0 == $past(COUNT0);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture value");
    property p_key_reads_zero;
        REG_REQ.rd && REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_SERVICE_KEY |=> REG_RDATA == 32'h0;
    endproperty
    a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");
    property p_cfg_reserved;
        REG_REQ.rd && REG_REQ.addr == csw_pkg::ADDR_CAPTURE_SOURCE_CONFIG
            |=> REG_RDATA[31:7] == 25'h0 && !REG_RDATA[3];
    endproperty
    a_cfg_reserved: assert property (p_cfg_reserved) else $error("config spare bits");
    property p_state_layout;
        REG_REQ.rd && REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_STATE
            |=> REG_RDATA[31:4] == 28'h0 && !REG_RDATA[0];
    endproperty
    a_state_layout: assert property (p_state_layout) else $error("state layout");
    property p_expired_state;
        WD_RESET_REQ && REG_REQ.rd && REG_REQ.addr == csw_pkg::ADDR_WATCHDOG_STATE
            |=> REG_RDATA[2:1] == 2'h3;
    endproperty
    a_expired_state: assert property (p_expired_state) else $error("expiry not shown");
    property p_wd_sticky;
        WD_RESET_REQ |=> WD_RESET_REQ;
    endproperty
    a_wd_sticky: assert property (p_wd_sticky) else $error("reset request dropped");
    property p_reset_quiet;
        $rose(RSTN) |-> (!WD_RESET_REQ && !IRQ) [*8];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
endmodule
bind csw_capture_watchdog csw_props #(.CNT_W(CNT_W)) csw_props_inst (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .COUNT0(COUNT0), .CAPTURE0_STROBE(CAPTURE0_STROBE), .CAPTURED0(CAPTURED0),
    .WD_RESET_REQ(WD_RESET_REQ), .IRQ(IRQ)
);

// ---- tb.sv ----
// testbench: register, capture and watchdog scenarios
`timescale 1ns/100ps
module tb;
    localparam logic [31:0] PRELOAD = 32'h20;
    localparam logic [31:0] A_CFG = csw_pkg::ADDR_CAPTURE_SOURCE_CONFIG;
    localparam logic [31:0] A_EN = csw_pkg::ADDR_WATCHDOG_ENABLE_CONTROL;
    localparam logic [31:0] A_PRE = csw_pkg::ADDR_WATCHDOG_PRELOAD_VALUE;
    localparam logic [31:0] A_ST = csw_pkg::ADDR_WATCHDOG_STATE;
    localparam logic [31:0] A_KEY = csw_pkg::ADDR_WATCHDOG_SERVICE_KEY;
    localparam logic [31:0] A_CNT = csw_pkg::ADDR_WATCHDOG_DOWN_COUNT;
    logic sys_clk;
    logic rstn;
    csw_pkg::csw_req_t reg_req;
    logic [31:0] reg_rdata;
    logic [5:0] fire;
    logic [5:0] dma_event;
    logic [31:0] cnt;
    logic cap0;
    logic cap1;
    logic [31:0] captured0;
    logic [31:0] captured1;
    logic wd_reset_req;
    logic irq;
    logic [31:0] word;
    int mismatches;
    int total_checks;
    int cyc;
    int n;
    csw_capture_watchdog #(.CNT_W(32), .PRELOAD_RESET(PRELOAD)) csw_capture_watchdog_inst (
        .SYS_CLK(sys_clk), .RSTN(rstn), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
        .DMA_EVENT(dma_event), .COUNT0(cnt), .COUNT1(~cnt), .CAPTURE0_STROBE(cap0),
        .CAPTURE1_STROBE(cap1), .CAPTURED0(captured0), .CAPTURED1(captured1),
        .WD_RESET_REQ(wd_reset_req), .IRQ(irq)
    );
    csw_dma_model csw_dma_model_inst (
        .sys_clk(sys_clk), .rstn(rstn), .fire(fire), .dma_event(dma_event)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cnt <= cnt + 32'h1;
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        // read data stands only in the cycle after the strobe
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask
    // pulse one source and see which capture channel answers
    task automatic pulse(input int src, input logic exp0, input logic exp1);
        logic seen0;
        logic seen1;
        seen0 = 1'b0;
        seen1 = 1'b0;
        @(posedge sys_clk);
        fire <= 6'h1 << src;
        @(posedge sys_clk);
        fire <= 6'h0;
        repeat (8)
        begin
            @(posedge sys_clk);
            #1;
            if (cap0)
            begin
                seen0 = 1'b1;
                chk(captured0, cnt - 32'h1);
            end
            if (cap1)
            begin
                seen1 = 1'b1;
                chk(captured1, ~(cnt - 32'h1));
            end
        end
        chk({31'h0, seen0}, {31'h0, exp0});
        chk({31'h0, seen1}, {31'h0, exp1});
    endtask
    initial
    begin
        rstn = 1'b0;
        reg_req = '0;
        fire = 6'h0;
        cnt = 32'h0;
        cyc = 0;
        mismatches = 0;
        total_checks = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(A_CFG, 32'h0);
        rd(A_ST, 32'h0);
        rd(A_CNT, PRELOAD);
        rd(A_KEY, 32'h0);
        rd(32'h42000000, 32'h0);
        wr(csw_pkg::ADDR_EVENT_MASK, 32'h1);
        // both selectors reset to port 0 transmit, so both channels answer
        pulse(0, 1'b1, 1'b1);
        chk({31'h0, irq}, 32'h1);
        rd(csw_pkg::ADDR_EVENT_STATUS, 32'h3);
        chk({31'h0, irq}, 32'h0);
        // only the six defined codes are ever programmed
        for (int s = 0; s < 6; s++)
        begin
            word = 32'(s) | (32'((s + 1) % 6) << 4);
            wr(A_CFG, word);
            rd(A_CFG, word);
            pulse(s, 1'b1, 1'b0);
            pulse((s + 1) % 6, 1'b0, 1'b1);
        end
        wr(A_PRE, 32'h30);
        rd(A_PRE, 32'h30);
        wr(csw_pkg::ADDR_EVENT_MASK, 32'h8);
        rd(csw_pkg::ADDR_EVENT_MASK, 32'h8);
        wr(A_EN, 32'h1);
        rd(A_EN, 32'h1);
        rd(A_ST, 32'h4);
        repeat (4)
        begin
            wr(A_KEY, {16'h0, csw_pkg::KEY_FIRST});
            rd(A_ST, 32'hc);
            wr(A_KEY, {16'h0, csw_pkg::KEY_SECOND});
            rd(A_CNT, 32'h2f);
        end
        wr(A_KEY, {16'h0, csw_pkg::KEY_FIRST});
        wr(A_KEY, 32'h1234);
        @(negedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        // capture events of the selector loop are still pending
        rd(csw_pkg::ADDR_EVENT_STATUS, 32'hb);
        chk({31'h0, wd_reset_req}, 32'h0);
        n = 0;
        while (wd_reset_req !== 1'b1 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, wd_reset_req}, 32'h1);
        rd(A_ST, 32'h6);
        rd(A_CNT, 32'h0);
        rd(csw_pkg::ADDR_EVENT_STATUS, 32'h4);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(A_ST, 32'h0);
        rd(A_CFG, 32'h0);
        rd(A_CNT, PRELOAD);
        chk({31'h0, wd_reset_req}, 32'h0);
        final_report();
    end
endmodule
